// >>> src/mqr_host.sv
// host end: register-driven controller that resets, selects and reads
// assumes software on a plain strobe port and the device on ref_clk
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module mqr_host
  import mqr_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // software port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [REG_DW-1:0]      reg_rdata,
  output logic                   irq,
  // link
  mqr_if.host                    link
);
  import mqr_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]        ctrl_reg;
  logic [3:0]        init_cnt_reg;
  logic              init_n_reg;
  logic [QADDR_W-1:0] addr_reg;
  logic              strobe_reg;
  logic              null_reg;
  logic              rd_en_n_reg;
  logic              rd_wait_reg;
  logic [DATA_W-1:0] data_reg;
  logic [ST_W-1:0]   stat_reg;
  logic [ST_W-1:0]   mask_reg;
  logic [REG_DW-1:0] rdata_reg;
  logic              irq_reg;
  logic [ST_W-1:0]   ev;
  logic              wv_seen;

  function automatic logic wr_at(input logic [3:0] ofs);
    return reg_wr && reg_addr == ofs;
  endfunction : wr_at

  // ------------------------------------------------------------
  // control and master reset pulse
  // ------------------------------------------------------------
  // a floating flag reads as not valid
  assign wv_seen = !link.word_valid_oe_n && !link.word_valid_n;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ctrl_reg <= CTRL_RST;
    else if (wr_at(OFS_CTRL))
      ctrl_reg <= {reg_wdata[7:1], 1'b0};
  end

  // init low for a fixed count, then released
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      init_cnt_reg <= 4'(INIT_CYCLES);
      init_n_reg   <= 1'b0;
    end
    else if (wr_at(OFS_CTRL) && reg_wdata[CTRL_INIT])
    begin
      init_cnt_reg <= 4'(INIT_CYCLES);
      init_n_reg   <= 1'b0;
    end
    else if (init_cnt_reg != 4'h0)
      init_cnt_reg <= init_cnt_reg - 4'h1;
    else
      init_n_reg <= 1'b1;
  end

  // ------------------------------------------------------------
  // selection and reads
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      addr_reg   <= '0;
      null_reg   <= 1'b0;
      strobe_reg <= 1'b0;
    end
    else
    begin
      strobe_reg <= wr_at(OFS_SEL) && init_n_reg;
      if (wr_at(OFS_SEL))
      begin
        addr_reg <= reg_wdata[QADDR_W-1:0];
        null_reg <= reg_wdata[SEL_NULL];
      end
    end
  end

  // one-cycle read, word sampled one cycle after the read edge
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rd_en_n_reg <= 1'b1;
      rd_wait_reg <= 1'b0;
      data_reg    <= '0;
    end
    else
    begin
      rd_en_n_reg <= ~(wr_at(OFS_READ) && init_n_reg);
      rd_wait_reg <= ~rd_en_n_reg;
      if (rd_wait_reg && wv_seen)
        data_reg <= link.q_out;
    end
  end

  // ------------------------------------------------------------
  // status, mask, interrupt
  // ------------------------------------------------------------
  assign ev[ST_WORD]  = rd_wait_reg && wv_seen;
  assign ev[ST_EMPTY] = rd_wait_reg && !wv_seen;
  assign ev[ST_INIT]  = init_cnt_reg == 4'h1;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      stat_reg <= '0;
    else if (wr_at(OFS_STAT))
      stat_reg <= (stat_reg & ~reg_wdata[ST_W-1:0]) | ev;
    else
      stat_reg <= stat_reg | ev;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      mask_reg <= MASK_RST;
    else if (wr_at(OFS_MASK))
      mask_reg <= reg_wdata[ST_W-1:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(stat_reg & mask_reg);
  end

  // read data the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rdata_reg <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        OFS_CTRL: rdata_reg <= {24'h000000, ctrl_reg};
        OFS_SEL:  rdata_reg <= {25'h0000000, null_reg, addr_reg};
        OFS_DATA: rdata_reg <= {14'h0000, data_reg};
        OFS_STAT: rdata_reg <= {29'h00000000, stat_reg};
        OFS_MASK: rdata_reg <= {29'h00000000, mask_reg};
        OFS_LINK: rdata_reg <= {28'h0000000, init_n_reg, link.q_oe_n,
                                link.word_valid_oe_n, link.word_valid_n};
        default:  rdata_reg <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata              = rdata_reg;
  assign irq                    = irq_reg;
  assign link.full_init_n       = init_n_reg;
  assign link.chain_lead_select = ctrl_reg[CTRL_LEAD];
  assign link.out_width_sel     = ctrl_reg[CTRL_OW];
  assign link.in_width_sel      = ctrl_reg[CTRL_IW];
  assign link.chip_number_pins  = ctrl_reg[CTRL_CHIP +: CHIP_W];
  assign link.rd_queue_addr     = addr_reg;
  assign link.rd_addr_strobe    = strobe_reg;
  assign link.null_q_sel        = null_reg;
  assign link.rd_en_n           = rd_en_n_reg;
  assign link.out_en_n          = ctrl_reg[CTRL_OEN];

endmodule : mqr_host

// >>> src/mqr_pkg.sv
// constants shared by the read-port output control, its host and the link
// assumes a single 25 MHz clock shared by both ends of the link
package mqr_pkg;

  // ------------------------------------------------------------
  // link widths
  // ------------------------------------------------------------
  localparam int QADDR_W  = 6;   // queue address: chip number + queue
  localparam int CHIP_W   = 3;   // upper address bits compared to pins
  localparam int QIDX_W   = 3;   // lower address bits pick a queue
  localparam int NUM_Q    = 8;
  localparam int DATA_W   = 18;
  localparam int NARROW_W = 9;   // narrow output bus width
  localparam int SEL_DEPTH = 2;  // selection to valid flag, in cycles

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS      = 40;
  localparam int INIT_LOW_NS = 200;  // least low time of full_init_n
  localparam int INIT_CYCLES = (INIT_LOW_NS + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------
  // host register map (word index on the software port)
  // ------------------------------------------------------------
  localparam int REG_AW  = 4;
  localparam int REG_DW  = 32;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_SEL  = 4'h1;
  localparam logic [3:0] OFS_READ = 4'h2;
  localparam logic [3:0] OFS_DATA = 4'h3;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h5;
  localparam logic [3:0] OFS_LINK = 4'h6;

  // ctrl fields
  localparam int CTRL_INIT  = 0;   // write 1: run a master reset
  localparam int CTRL_LEAD  = 1;
  localparam int CTRL_OW    = 2;
  localparam int CTRL_IW    = 3;
  localparam int CTRL_CHIP  = 4;   // 3 bits
  localparam int CTRL_OEN   = 7;   // out_en_n level
  localparam logic [7:0] CTRL_RST = 8'h82;  // lead, outputs disabled

  // sel fields
  localparam int SEL_NULL = 6;

  // status / mask bits
  localparam int ST_W     = 3;
  localparam int ST_WORD  = 0;   // word captured
  localparam int ST_EMPTY = 1;   // read found no valid word
  localparam int ST_INIT  = 2;   // master reset finished
  localparam logic [2:0] MASK_RST = 3'h0;

endpackage : mqr_pkg

// >>> src/mqr_if.sv
// read-port link between a queue device and the host that reads it
// assumes both ends share ref_clk; tri-state lines come as value+enable
`timescale 1ns/100ps
interface mqr_if;
  import mqr_pkg::*;

  // configuration and master reset
  logic                    full_init_n;
  logic                    chain_lead_select;
  logic                    out_width_sel;
  logic                    in_width_sel;
  logic [CHIP_W-1:0]       chip_number_pins;
  // read port selection and reads
  logic [QADDR_W-1:0]      rd_queue_addr;
  logic                    rd_addr_strobe;
  logic                    null_q_sel;
  logic                    rd_en_n;
  logic                    out_en_n;
  // three-state outputs of the device
  logic [DATA_W-1:0]       q_out;
  logic                    q_oe_n;
  logic                    word_valid_n;
  logic                    word_valid_oe_n;

  modport dev (
    input  full_init_n, chain_lead_select, out_width_sel, in_width_sel,
    input  chip_number_pins, rd_queue_addr, rd_addr_strobe, null_q_sel,
    input  rd_en_n, out_en_n,
    output q_out, q_oe_n, word_valid_n, word_valid_oe_n
  );

  modport host (
    output full_init_n, chain_lead_select, out_width_sel, in_width_sel,
    output chip_number_pins, rd_queue_addr, rd_addr_strobe, null_q_sel,
    output rd_en_n, out_en_n,
    input  q_out, q_oe_n, word_valid_n, word_valid_oe_n
  );

endinterface : mqr_if

// >>> src/mqr_dev.sv
// device end: read-port output control of one chainable queue device
// assumes queue memory outside: it shows the head word and empty bits
// of every queue and advances a queue on the pop pulse
//
// Summary of operation
// - lead-select high at init: chain master
// - master drives outputs first after init
// - slaves float outputs after init
// - lone device: host holds lead-select high
// - host pulses full_init_n low then high
// - host reprograms after every init
// - null queue: null select with address strobe
// - output enable acts with no clock
// - master drives data when enable low
// - master floats data when enable high
// - slave floats data until selected
// - valid flag follows selection two cycles
// - read to empty raises valid flag
// - valid flag can float for chaining
// - out width sampled: low 18, high 9
// - in width sampled: low 18, high 9
// - upper address bits matched to chip pins
`timescale 1ns/100ps
module mqr_dev
  import mqr_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // link
  mqr_if.dev                     link,
  // queue memory side
  input  wire logic [DATA_W-1:0] head_data [NUM_Q],
  input  wire logic [NUM_Q-1:0]  q_empty,
  output logic [QIDX_W-1:0]      pop_queue,
  output logic                   pop,
  // configuration as latched
  output logic                   is_lead,
  output logic                   out_narrow,
  output logic                   in_narrow
);
  import mqr_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic              lead_reg;
  logic              ow_reg;
  logic              iw_reg;
  logic [CHIP_W-1:0] chip_reg;
  logic              init_reg;      // in master reset
  logic              s1_load_reg;
  logic              s1_hit_reg;
  logic              s1_null_reg;
  logic [QIDX_W-1:0] s1_q_reg;
  logic              act_hit_reg;
  logic              act_null_reg;
  logic [QIDX_W-1:0] act_q_reg;
  logic [DATA_W-1:0] q_out_reg;
  logic              valid_n_reg;
  logic              wv_oe_n_reg;
  logic              drive_ok_reg;
  logic              hit;
  logic              can_pop;

  // chip-number compare, used for strobes
  function automatic logic chip_match(input logic [QADDR_W-1:0] a,
                                      input logic [CHIP_W-1:0] id);
    return a[QADDR_W-1 -: CHIP_W] == id;
  endfunction : chip_match

  // ------------------------------------------------------------
  // configuration capture
  // ------------------------------------------------------------
  // sampled every cycle of the init pulse, frozen at its release
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      lead_reg <= 1'b1;
      ow_reg   <= 1'b0;
      iw_reg   <= 1'b0;
      chip_reg <= '0;
      init_reg <= 1'b1;
    end
    else
    begin
      init_reg <= ~link.full_init_n;
      if (!link.full_init_n)
      begin
        lead_reg <= link.chain_lead_select;
        ow_reg   <= link.out_width_sel;
        iw_reg   <= link.in_width_sel;
        chip_reg <= link.chip_number_pins;
      end
    end
  end

  // ------------------------------------------------------------
  // selection pipeline
  // ------------------------------------------------------------
  assign hit = chip_match(link.rd_queue_addr, chip_reg);

  // first stage takes the strobe, second stage is the live queue
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !link.full_init_n)
    begin
      s1_load_reg  <= 1'b0;
      s1_hit_reg   <= 1'b0;
      s1_null_reg  <= 1'b0;
      s1_q_reg     <= '0;
      act_hit_reg  <= 1'b0;
      act_null_reg <= 1'b0;
      act_q_reg    <= '0;
    end
    else
    begin
      s1_load_reg <= link.rd_addr_strobe;
      if (link.rd_addr_strobe)
      begin
        s1_hit_reg  <= hit;
        s1_null_reg <= link.null_q_sel;
        s1_q_reg    <= link.rd_queue_addr[QIDX_W-1:0];
      end
      if (s1_load_reg)
      begin
        act_hit_reg  <= s1_hit_reg;
        act_null_reg <= s1_null_reg;
        act_q_reg    <= s1_q_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // ownership of the shared lines
  // ------------------------------------------------------------
  // data drive permission; master keeps it, slave needs selection
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !link.full_init_n)
      drive_ok_reg <= 1'b0;
    else if (init_reg)
      drive_ok_reg <= lead_reg;
    else if (lead_reg)
      drive_ok_reg <= 1'b1;
    else if (link.rd_addr_strobe)
      drive_ok_reg <= hit;
  end

  // ------------------------------------------------------------
  // reads
  // ------------------------------------------------------------
  assign can_pop = act_hit_reg && !act_null_reg && !q_empty[act_q_reg];
  assign pop       = !link.rd_en_n && can_pop && !init_reg;
  assign pop_queue = act_q_reg;

  // output word; narrow mode leaves the upper lines low
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !link.full_init_n)
      q_out_reg <= '0;
    else if (pop)
    begin
      if (ow_reg)
        q_out_reg <= {{(DATA_W-NARROW_W){1'b0}},
                      head_data[act_q_reg][NARROW_W-1:0]};
      else
        q_out_reg <= head_data[act_q_reg];
    end
  end

  // valid flag: a new queue starts invalid, a failed read goes invalid
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !link.full_init_n)
      valid_n_reg <= 1'b1;
    else if (s1_load_reg)
      valid_n_reg <= 1'b1;
    else if (pop)
      valid_n_reg <= 1'b0;
    else if (!link.rd_en_n)
      valid_n_reg <= 1'b1;
  end

  // flag line floats unless this device owns the port
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !link.full_init_n)
      wv_oe_n_reg <= 1'b1;
    else if (init_reg)
      wv_oe_n_reg <= ~lead_reg;
    else if (link.rd_addr_strobe)
      wv_oe_n_reg <= ~hit;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // enable path is combinational so out_en_n takes effect at once
  assign link.q_oe_n = link.out_en_n | ~drive_ok_reg;
  assign link.q_out           = q_out_reg;
  assign link.word_valid_n    = valid_n_reg;
  assign link.word_valid_oe_n = wv_oe_n_reg;
  assign is_lead    = lead_reg;
  assign out_narrow = ow_reg;
  assign in_narrow  = iw_reg;

endmodule : mqr_dev

// >>> verif/mqr_link_asserts.sv
// checker on the read-port link between host and device ends
// assumes one ref_clk domain and a single device on the link
`timescale 1ns/100ps
module mqr_link_asserts
  import mqr_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  // link lines
  input wire logic              full_init_n,
  input wire logic              chain_lead_select,
  input wire logic              out_width_sel,
  input wire logic              rd_addr_strobe,
  input wire logic              rd_en_n,
  input wire logic              out_en_n,
  input wire logic [DATA_W-1:0] q_out,
  input wire logic              q_oe_n,
  input wire logic              word_valid_n,
  input wire logic              word_valid_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // role and drive after master reset
  // ------------------------------------------------------------
  init_data_off_a: assert property (!full_init_n |=> q_oe_n)
    else $error("data bus driven during master reset");
  init_flag_off_a: assert property (!full_init_n |=> word_valid_oe_n)
    else $error("valid flag driven during master reset");
  lead_takes_flag_a: assert property (
    $rose(full_init_n) && chain_lead_select |-> ##[1:2] !word_valid_oe_n)
    else $error("master did not take the flag line");
  slave_floats_a: assert property (
    $rose(full_init_n) && !chain_lead_select
      |-> (q_oe_n && word_valid_oe_n) [*3])
    else $error("slave drove lines after master reset");
  // enable acts in the same cycle, no edge between
  oe_async_a: assert property (out_en_n |-> q_oe_n)
    else $error("data bus driven while output enable high");
  master_drive_a: assert property (
    chain_lead_select && !out_en_n && full_init_n
      && $past(full_init_n, 3) |-> !q_oe_n)
    else $error("master floated data while output enable low");

  // ------------------------------------------------------------
  // valid flag and output width
  // ------------------------------------------------------------
  new_queue_invalid_a: assert property (
    rd_addr_strobe && full_init_n |-> ##2 word_valid_n)
    else $error("flag not invalid two cycles after selection");
  valid_from_read_a: assert property (
    $fell(word_valid_n) |-> !$past(rd_en_n))
    else $error("flag went valid without a read");
  narrow_upper_zero_a: assert property (
    out_width_sel && $past(out_width_sel, 8) && !word_valid_n
      |-> q_out[DATA_W-1:NARROW_W] == '0)
    else $error("upper data bits set in narrow mode");
endmodule : mqr_link_asserts

// >>> verif/test_multiqueue_read_output_control.sv
// testbench: host and device joined by the link, software port driven
// assumes the bench models queue memory: a new random word on each pop
`timescale 1ns/100ps
module test_multiqueue_read_output_control;
  import mqr_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              ref_clk;
  logic              sys_rst;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [REG_DW-1:0] reg_rdata;
  logic              irq;
  logic [DATA_W-1:0] head_data [NUM_Q];
  logic [NUM_Q-1:0]  q_empty;
  logic [QIDX_W-1:0] pop_queue;
  logic              pop;
  logic              is_lead;
  logic              out_narrow;
  logic              in_narrow;
  logic              rd_d;
  logic [REG_DW-1:0] exp_q [$];
  logic [DATA_W-1:0] word;
  int                n_fail;
  int                cmp_count;
  int                cycles;

  mqr_if u_mqr_if();

  mqr_dev u_mqr_dev (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .link      (u_mqr_if),
    .head_data (head_data),
    .q_empty   (q_empty),
    .pop_queue (pop_queue),
    .pop       (pop),
    .is_lead   (is_lead),
    .out_narrow(out_narrow),
    .in_narrow (in_narrow)
  );

  mqr_host u_mqr_host (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .reg_addr (reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr   (reg_wr),
    .reg_rd   (reg_rd),
    .reg_rdata(reg_rdata),
    .irq      (irq),
    .link     (u_mqr_if)
  );

  mqr_link_asserts u_mqr_link_asserts (
    .ref_clk          (ref_clk),
    .sys_rst          (sys_rst),
    .full_init_n      (u_mqr_if.full_init_n),
    .chain_lead_select(u_mqr_if.chain_lead_select),
    .out_width_sel    (u_mqr_if.out_width_sel),
    .rd_addr_strobe   (u_mqr_if.rd_addr_strobe),
    .rd_en_n          (u_mqr_if.rd_en_n),
    .out_en_n         (u_mqr_if.out_en_n),
    .q_out            (u_mqr_if.q_out),
    .q_oe_n           (u_mqr_if.q_oe_n),
    .word_valid_n     (u_mqr_if.word_valid_n),
    .word_valid_oe_n  (u_mqr_if.word_valid_oe_n)
  );

  // ------------------------------------------------------------
  // clock, memory model, watchdog, result monitor
  // ------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // popped queue shows a fresh random head word
  always @(posedge ref_clk)
  begin
    if (pop === 1'b1)
      head_data[pop_queue] <= DATA_W'($urandom);
  end

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // read data stand from the cycle after the strobe until the next read; checked in that cycle
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk)
  begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front());
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [REG_DW-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
  endtask : rd

  // select a queue, then pulse one read on it; a word pops only if the queue holds one
  task automatic sel_read(input logic [REG_DW-1:0] s);
    wr(OFS_SEL, s);
    idle(4);
    wr(OFS_READ, 32'h0000_0000);
    idle(6);
  endtask : sel_read

  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_rst   = 1'b1;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    q_empty   = 8'h20;
    void'($urandom(3540));
    foreach (head_data[i]) head_data[i] = DATA_W'($urandom);
    idle(20);
    sys_rst <= 1'b0;
    idle(12);
    rd(OFS_CTRL, 32'h0000_0082);
    rd(OFS_MASK, 32'h0000_0000);
    rd(4'hF, 32'h0000_0000);
    rd(OFS_STAT, 32'h0000_0004);
    rd(OFS_LINK, 32'h0000_000D);
    check(32'({is_lead, out_narrow, in_narrow}), 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0002);
    idle(2);
    rd(OFS_LINK, 32'h0000_0009);
    wr(OFS_STAT, 32'h0000_0007);
    wr(OFS_MASK, 32'h0000_0003);
    // every queue, queue 5 held empty
    for (int q = 0; q < NUM_Q; q++)
    begin
      word = head_data[q];
      sel_read(32'(q));
      if (q == 5)
        rd(OFS_STAT, 32'h0000_0002);
      else
        rd(OFS_DATA, 32'(word));
      idle(2);
      check(32'(irq), 32'h0000_0001);
      wr(OFS_STAT, 32'h0000_0007);
      idle(3);
      check(32'(irq), 32'h0000_0000);
    end
    // null queue never gives a word
    sel_read(32'h0000_0041);
    rd(OFS_STAT, 32'h0000_0002);
    // narrow output, flags masked
    wr(OFS_MASK, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_000F);
    idle(12);
    check(32'({is_lead, out_narrow, in_narrow}), 32'h0000_0007);
    word = head_data[1];
    sel_read(32'h0000_0001);
    rd(OFS_DATA, 32'(word[NARROW_W-1:0]));
    check(32'(irq), 32'h0000_0000);
    // width pins change with no master reset: latched values stay
    wr(OFS_CTRL, 32'h0000_0002);
    idle(2);
    check(32'({is_lead, out_narrow, in_narrow}), 32'h0000_0007);
    // slave floats until a matching selection
    wr(OFS_CTRL, 32'h0000_0001);
    idle(12);
    rd(OFS_LINK, 32'h0000_000F);
    check(32'({is_lead, out_narrow, in_narrow}), 32'h0000_0000);
    wr(OFS_SEL, 32'h0000_0008);
    idle(4);
    rd(OFS_LINK, 32'h0000_000F);
    wr(OFS_SEL, 32'h0000_0000);
    idle(4);
    rd(OFS_LINK, 32'h0000_0009);
    idle(4);
    report_and_stop();
  end
endmodule : test_multiqueue_read_output_control
